// ===== hdl/flash_ctrl_pkg.sv
package flash_ctrl_pkg;

  // register window offset, low address bits only
  localparam int ADDR_LOW_W = 12;
  localparam logic [ADDR_LOW_W-1:0] CTRL_OFS = 12'h100;

  // field positions in the control word
  localparam int SUSP_EN_BIT = 18;
  localparam int SLEEP_BIT = 17;
  localparam int DMA_BIT = 16;
  localparam int FAULT_EN_BIT = 15;
  localparam int FAULT_BIT = 14;
  localparam int IRQ_CLR_BIT = 13;
  localparam int WAIT_LSB = 10;
  localparam int WAIT_W = 3;
  localparam int SLEEP_REQ_BIT = 2;

  // values after reset
  localparam logic [WAIT_W-1:0] WAIT_RST = 3'h3;
  localparam logic SLEEP_RST = 1'b1;

  typedef struct packed {
    logic suspendAllow;
    logic dmaPace;
    logic faultReplyAllow;
    logic [WAIT_W-1:0] waitCount;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{suspendAllow: 1'b0, dmaPace: 1'b0,
                                 faultReplyAllow: 1'b0, waitCount: WAIT_RST};

  typedef enum logic [1:0] {BUS_IDLE, BUS_RDWAIT, BUS_ERR1, BUS_ERR2} bus_state_e;

endpackage

// ===== hdl/wait_counter.sv
`timescale 1ns/1ns
module wait_counter #(
  parameter int W = 3
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  output logic zero
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = loadVal;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign zero = (cnt_q == '0);
endmodule

// ===== hdl/flash_ctrl_bus.sv
// How it works
// - erase suspend permitted only while suspend-allow bit is 1; resets to 0.
// - sleep status reads 1 after reset; next read clears it and wakes.
// - dma pacing bit 1 gives write handshake and suppresses interrupt.
// - fault-reply-allow enables error response; never alters the fault flag.
// - fault-reply-allow can only be set by software; reset clears it.
// - fault flag is 1 when the latest unit access caused a bus error.
// - fault flag is cleared by the next unit access that does not itself fault.
// - writing 1 to interrupt-clear drops pending interrupt; 0 does nothing.
// - 3-bit wait count, 0 to 7, resets to 3, paces array reads.
// - writing 1 to sleep-request puts flash asleep; a read wakes it.
`timescale 1ns/1ns
module flash_ctrl_bus #(
  parameter int AW = 18
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hselReg,
  input wire logic hselArray,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [AW-1:0] flashAddr,
  output logic flashRd,
  input wire logic [31:0] flashRdata,
  input wire logic accessDenied,
  input wire logic opDone,
  input wire logic wrSlotFree,
  output logic dmaReq,
  output logic irq,
  output logic flashSleep,
  output logic eraseSuspendAllow
);
  import flash_ctrl_pkg::*;

  flash_ctrl_pkg::ctrl_s ctrl_q, ctrl_d;
  bus_state_e state_q, state_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic sleep_q, sleep_d;
  logic busFault_q, busFault_d;
  logic pending_q, pending_d;
  logic wrPend_q, wrPend_d;
  logic accept, regHit, arrayRd, faultAcc, cntZero;
  logic [31:0] ctrlWord;

  // transfer taken in its address phase
  assign accept = (hselReg | hselArray) & htrans[1] & hready;
  assign regHit = hselReg & (haddr[ADDR_LOW_W-1:0] == CTRL_OFS);
  // array writes are not served here and count as faults, as do denied reads
  assign faultAcc = accept & hselArray & (accessDenied | hwrite);
  assign arrayRd = accept & hselArray & !hwrite & !accessDenied;

  always_comb begin
    ctrlWord = 32'h0000_0000;
    ctrlWord[SUSP_EN_BIT] = ctrl_q.suspendAllow;
    ctrlWord[SLEEP_BIT] = sleep_q;
    ctrlWord[DMA_BIT] = ctrl_q.dmaPace;
    ctrlWord[FAULT_EN_BIT] = ctrl_q.faultReplyAllow;
    ctrlWord[FAULT_BIT] = busFault_q;
    ctrlWord[WAIT_LSB +: WAIT_W] = ctrl_q.waitCount;
  end

  wait_counter #(.W(WAIT_W)) u_wait (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(arrayRd),
    .loadVal(ctrl_q.waitCount),
    .zero(cntZero)
  );

  // control register and flags
  always_comb begin
    ctrl_d = ctrl_q;
    sleep_d = sleep_q;
    busFault_d = busFault_q;
    pending_d = pending_q;
    wrPend_d = accept & regHit & hwrite;
    if (wrPend_q) begin
      ctrl_d.suspendAllow = hwdata[SUSP_EN_BIT];
      ctrl_d.dmaPace = hwdata[DMA_BIT];
      ctrl_d.faultReplyAllow = ctrl_q.faultReplyAllow | hwdata[FAULT_EN_BIT];
      ctrl_d.waitCount = hwdata[WAIT_LSB +: WAIT_W];
      if (hwdata[SLEEP_REQ_BIT]) begin
        sleep_d = 1'b1;
      end
      if (hwdata[IRQ_CLR_BIT]) begin
        pending_d = 1'b0;
      end
    end
    if (accept & !hwrite) begin
      sleep_d = 1'b0;
    end
    if (opDone) begin
      pending_d = 1'b1;
    end
    if (accept) begin
      busFault_d = faultAcc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RST;
      sleep_q <= SLEEP_RST;
      busFault_q <= 1'b0;
      pending_q <= 1'b0;
      wrPend_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      sleep_q <= sleep_d;
      busFault_q <= busFault_d;
      pending_q <= pending_d;
      wrPend_q <= wrPend_d;
    end
  end

  // bus data phase sequencing
  always_comb begin
    state_d = state_q;
    hrdata_d = hrdata_q;
    unique case (state_q)
      BUS_IDLE, BUS_ERR2: begin
        state_d = BUS_IDLE;
        if (faultAcc & ctrl_q.faultReplyAllow) begin
          state_d = BUS_ERR1;
        end else if (arrayRd) begin
          state_d = BUS_RDWAIT;
        end else if (accept & !hwrite) begin
          hrdata_d = regHit ? ctrlWord : 32'h0000_0000;
        end
      end
      BUS_RDWAIT: begin
        if (cntZero) begin
          hrdata_d = flashRdata;
          state_d = BUS_IDLE;
        end
      end
      BUS_ERR1: state_d = BUS_ERR2;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= BUS_IDLE;
      hrdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      hrdata_q <= hrdata_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = (state_q == BUS_IDLE) | (state_q == BUS_ERR2);
  assign hresp = (state_q == BUS_ERR1) | (state_q == BUS_ERR2);
  assign flashAddr = haddr[AW-1:0];
  assign flashRd = arrayRd;
  assign irq = pending_q & !ctrl_q.dmaPace;
  assign dmaReq = ctrl_q.dmaPace & wrSlotFree;
  assign flashSleep = sleep_q;
  assign eraseSuspendAllow = ctrl_q.suspendAllow;

  // checks
  property p_suspend_write;
    @(posedge ref_clk) disable iff (!resetn)
    wrPend_q |=> eraseSuspendAllow == $past(hwdata[SUSP_EN_BIT]);
  endproperty
  a_suspend_write: assert property (p_suspend_write) else $error("suspend-allow not written");

  property p_sleep_wake;
    @(posedge ref_clk) disable iff (!resetn)
    (accept & !hwrite) |=> !flashSleep;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("read did not wake flash");

  property p_sleep_req;
    @(posedge ref_clk) disable iff (!resetn)
    (wrPend_q & hwdata[SLEEP_REQ_BIT] & !(accept & !hwrite)) |=> flashSleep;
  endproperty
  a_sleep_req: assert property (p_sleep_req) else $error("sleep request ignored");

  property p_dma_no_irq;
    @(posedge ref_clk) disable iff (!resetn)
    (opDone & !ctrl_q.dmaPace & !wrPend_q) |=> irq;
  endproperty
  a_dma_no_irq: assert property (p_dma_no_irq) else $error("interrupt not raised");

  property p_dma_mask;
    @(posedge ref_clk) disable iff (!resetn)
    (opDone & ctrl_q.dmaPace & !wrPend_q) |=> !irq;
  endproperty
  a_dma_mask: assert property (p_dma_mask) else $error("interrupt raised under dma pacing");

  property p_err_reply;
    @(posedge ref_clk) disable iff (!resetn)
    (faultAcc & ctrl_q.faultReplyAllow & hreadyout) |=> (hresp & !hreadyout) ##1 (hresp & hreadyout);
  endproperty
  a_err_reply: assert property (p_err_reply) else $error("error response malformed");

  property p_no_reply;
    @(posedge ref_clk) disable iff (!resetn)
    (faultAcc & !ctrl_q.faultReplyAllow & hreadyout) |=> !hresp && busFault_q;
  endproperty
  a_no_reply: assert property (p_no_reply) else $error("reply while disabled");

  property p_fault_sticky;
    @(posedge ref_clk) disable iff (!resetn)
    ctrl_q.faultReplyAllow |=> ctrl_q.faultReplyAllow;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("reply enable cleared");

  property p_fault_clear;
    @(posedge ref_clk) disable iff (!resetn)
    (accept & !faultAcc) |=> !busFault_q;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault flag not cleared");

  property p_irq_clear;
    @(posedge ref_clk) disable iff (!resetn)
    (wrPend_q & hwdata[IRQ_CLR_BIT] & !opDone) |=> !pending_q;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");

  property p_wait0;
    @(posedge ref_clk) disable iff (!resetn)
    (arrayRd & ctrl_q.waitCount == 3'h0) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait0: assert property (p_wait0) else $error("zero-wait read timing");

  property p_wait7;
    @(posedge ref_clk) disable iff (!resetn)
    (arrayRd & ctrl_q.waitCount == 3'h7) |=> !hreadyout [*8] ##1 hreadyout;
  endproperty
  a_wait7: assert property (p_wait7) else $error("seven-wait read timing");

  c_slow_read: cover property (@(posedge ref_clk) disable iff (!resetn)
    arrayRd ##1 !hreadyout [*4] ##1 hreadyout);
  c_err: cover property (@(posedge ref_clk) disable iff (!resetn) state_q == BUS_ERR2);
  c_wake: cover property (@(posedge ref_clk) disable iff (!resetn) flashSleep ##1 !flashSleep);
endmodule

// ===== tb/flash_array_model.sv
`timescale 1ns/1ns
module flash_array_model (
  input wire logic ref_clk,
  input wire logic flashRd,
  input wire logic [17:0] flashAddr,
  input wire logic hreadyout,
  output logic [31:0] flashRdata
);
  logic [31:0] word = '0;
  logic busy = 1'b0;
  // word valid only while the read is open, inverted after
  always @(posedge ref_clk) begin
    if (flashRd) begin
      word <= {flashAddr[13:0], ~flashAddr};
      busy <= 1'b1;
    end else if (hreadyout) begin
      busy <= 1'b0;
    end
  end
  assign flashRdata = busy ? word : ~word;
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import flash_ctrl_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, hselReg = 1'b0, hselArray = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, flashRdata, seed = 32'hC0664D88, a;
  logic [1:0] htrans = 2'h0;
  logic hready, hreadyout, hresp, flashRd, dmaReq, irq, flashSleep, eraseSuspendAllow;
  logic accessDenied = 1'b0, opDone = 1'b0, wrSlotFree = 1'b1, inData = 1'b0;
  logic [17:0] flashAddr;
  logic [37:0] q[$];
  logic [37:0] e;
  logic [3:0] lowCnt;
  int error_cnt = 0, num_checks = 0, cycles = 0;
  localparam logic [31:0] W3 = 32'h0000_0C00;
  assign hready = hreadyout;
  initial forever #20 ref_clk = ~ref_clk;
  flash_ctrl_bus flash_ctrl_bus_inst (.ref_clk(ref_clk), .resetn(resetn),
    .hselReg(hselReg), .hselArray(hselArray), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flashAddr(flashAddr), .flashRd(flashRd),
    .flashRdata(flashRdata), .accessDenied(accessDenied), .opDone(opDone),
    .wrSlotFree(wrSlotFree), .dmaReq(dmaReq), .irq(irq), .flashSleep(flashSleep),
    .eraseSuspendAllow(eraseSuspendAllow));
  flash_array_model flash_array_model_inst (.ref_clk(ref_clk), .flashRd(flashRd),
    .flashAddr(flashAddr), .hreadyout(hreadyout), .flashRdata(flashRdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ex: read flag, error reply, not-ready cycles, read data
  task automatic xfer(input logic arr, input logic wr, input logic [31:0] ad,
                      input logic [31:0] d, input logic [37:0] ex);
    int n;
    n = 0;
    q.push_back(ex);
    @(posedge ref_clk);
    hselArray <= arr;
    hselReg <= !arr;
    haddr <= ad;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge ref_clk);
    hselArray <= 1'b0;
    hselReg <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 20);
    if (hreadyout !== 1'b1) error_cnt++;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [31:0] v);
    xfer(1'b0, 1'b0, {20'h0, CTRL_OFS}, '0, {2'b10, 4'h0, v});
  endtask
  task automatic wr(input logic [31:0] v);
    xfer(1'b0, 1'b1, {20'h0, CTRL_OFS}, v, '0);
  endtask
  task automatic pulse();
    @(posedge ref_clk);
    opDone <= 1'b1;
    @(posedge ref_clk);
    opDone <= 1'b0;
    @(negedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (inData) begin
      if (hreadyout === 1'b1) begin
        e = q.pop_front();
        inData = 1'b0;
        chk({hresp, lowCnt}, e[36:32]);
        if (e[37]) chk(hrdata, e[31:0]);
      end else begin
        lowCnt++;
      end
    end
    if (resetn && hready && (hselReg || hselArray) && htrans[1]) begin
      inData = 1'b1;
      lowCnt = 4'h0;
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk({flashSleep, eraseSuspendAllow, irq, dmaReq}, 4'b1000);
    rd(W3 | 32'h2_0000);
    chk(flashSleep, 1'b0);
    wr(W3 | 32'h4);
    chk(flashSleep, 1'b1);
    rd(W3 | 32'h2_0000);
    chk(flashSleep, 1'b0);
    $display("test sleep done");
    xfer(1'b1, 1'b1, '0, '0, '0);
    rd(W3 | 32'h4000);
    rd(W3);
    pulse();
    chk(irq, 1'b1);
    wr(W3);
    chk(irq, 1'b1);
    wr(W3 | 32'h2000);
    chk(irq, 1'b0);
    wr(32'h0005_9400);
    chk({eraseSuspendAllow, dmaReq}, 2'b11);
    @(posedge ref_clk);
    wrSlotFree <= 1'b0;
    pulse();
    chk({dmaReq, irq}, 2'b00);
    rd(32'h0005_9400);
    wr('0);
    chk({eraseSuspendAllow, irq}, 2'b01);
    rd(32'h0000_8000);
    @(posedge ref_clk);
    wrSlotFree <= 1'b1;
    $display("test control done");
    // zero waits allowed since ref_clk is far below 64 MHz
    for (int w = 0; w < 8; w++) begin
      wr(32'(w) << 10);
      seed = xs(seed);
      a = seed & 32'h0003_FFFF;
      xfer(1'b1, 1'b0, a, '0, {2'b10, 4'(w + 1), a[13:0], ~a[17:0]});
    end
    $display("test array reads done");
    xfer(1'b1, 1'b1, a, seed, {2'b01, 4'h1, 32'h0});
    @(posedge ref_clk);
    accessDenied <= 1'b1;
    xfer(1'b1, 1'b0, a, '0, {2'b01, 4'h1, 32'h0});
    @(posedge ref_clk);
    accessDenied <= 1'b0;
    rd(32'h0000_DC00);
    $display("test faults done");
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    rd(W3 | 32'h2_0000);
    xfer(1'b1, 1'b1, '0, '0, '0);
    chk(q.size(), 0);
    $display("test reset done");
    test_done();
  end
endmodule
